// ==== logic/core_defs.vh ====
/*
 * Constants for the accumulator, move and clear instruction group:
 * opcodes, field positions, status bit positions, register offsets
 * and reset values.
 * Assumes it is included by bare name in every design file that needs it.
 */
`ifndef CORE_DEFS_VH
`define CORE_DEFS_VH

// ----------------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------------
`define WORD_W           12
`define OP_IDLE          12'h000
`define OP_KICK          12'h004
`define OP_CLEAR_ACC     12'h040
`define STORE_PREFIX     7'h01
`define STORE_HI         11
`define STORE_LO         5
`define COPY_PREFIX      6'h08
`define COPY_HI          11
`define COPY_LO          6
`define LITERAL_PREFIX   4'hC
`define LITERAL_HI       11
`define LITERAL_LO       8
`define INDEX_HI         4
`define DEST_BIT         5
`define IMM_HI           7

// ----------------------------------------------------------------------
// Status bit positions and reset values
// ----------------------------------------------------------------------
`define ST_ZERO          2
`define ST_SLEEP         3
`define ST_EXPIRY        4
`define ACC_RESET        8'h00
`define ZERO_RESET       1'b0
`define SLEEP_RESET      1'b1
`define EXPIRY_RESET     1'b1
`define CTRL_RESET       1'b0
`define BYTE_ZERO        8'h00

// ----------------------------------------------------------------------
// Register offsets and bus answers
// ----------------------------------------------------------------------
`define REG_ACCUM        8'h00
`define REG_STATUS       8'h04
`define REG_CONTROL      8'h08
`define REG_RETIRED      8'h0C
`define CTRL_PSA_BIT     0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== logic/file_regs.v ====
/*
 * File register array: 32 bytes, one write port, one read port whose
 * data leave a register one clock after the address.
 * Assumes the caller forwards a write that collides with a read.
 */
`timescale 1ns/1ps
`include "core_defs.vh"

module file_regs (
    // Clock
    input  wire       clock,
    // Write port
    input  wire       wr_en,
    input  wire [4:0] wr_addr,
    input  wire [7:0] wr_data,
    // Read port
    input  wire [4:0] rd_addr,
    output reg  [7:0] rd_data
);

    reg [7:0] cells [0:31];

    always @(posedge clock) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
        rd_data <= cells[rd_addr];
    end

endmodule // file_regs

// ==== logic/op_decoder.v ====
/*
 * Combinational decoder that turns one instruction word into one flag
 * per operation of this group.
 * Assumes the word is stable for the cycle in which it is decoded.
 */
`timescale 1ns/1ps
`include "core_defs.vh"

module op_decoder (
    // Instruction word
    input  wire [11:0] word,
    // Operation flags
    output wire        clear_accumulator_op,
    output wire        watchdog_kick_op,
    output wire        register_copy_op,
    output wire        accumulator_store_op,
    output wire        literal_load_op,
    output wire        idle_op
);

    assign clear_accumulator_op = (word == `OP_CLEAR_ACC);
    assign watchdog_kick_op     = (word == `OP_KICK);
    assign register_copy_op     =
        (word[`COPY_HI:`COPY_LO] == `COPY_PREFIX);
    assign accumulator_store_op =
        (word[`STORE_HI:`STORE_LO] == `STORE_PREFIX);
    assign literal_load_op      =
        (word[`LITERAL_HI:`LITERAL_LO] == `LITERAL_PREFIX);
    assign idle_op              = (word == `OP_IDLE);

endmodule // op_decoder

// ==== logic/move_clear_unit.v ====
/*
 * Execution unit for clear-accumulator, watchdog-kick, register-copy,
 * accumulator-store, literal-load and idle, with an AXI4-Lite slave for
 * the accumulator, status, control and retired-count registers.
 * Assumes the fetch path offers at most one word per clock and that the
 * watchdog and prescaler act on the one-cycle clear pulses driven here.
 */
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "core_defs.vh"

module move_clear_unit (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // Instruction fetch
    input  wire [11:0] instr_word,
    input  wire        instr_valid,
    // Core outputs
    output reg  [7:0]  accumulator,
    output reg         watchdog_clear,
    output reg         prescaler_clear,
    output reg         pc_advance,
    // AXI4-Lite write address and data
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ------------------------------------------------------------------
    // Decode and execute stage
    // ------------------------------------------------------------------
    wire       dec_clear;
    wire       dec_kick;
    wire       dec_copy;
    wire       dec_store;
    wire       dec_literal;
    wire [7:0] mem_rdata;

    reg        ex_valid;
    reg        ex_clear;
    reg        ex_kick;
    reg        ex_copy;
    reg        ex_store;
    reg        ex_literal;
    reg        ex_dest;
    reg  [4:0] ex_index;
    reg  [7:0] ex_imm;
    reg        fwd_hit;
    reg  [7:0] fwd_data;

    reg        zero_flag;
    reg        sleep_flag;
    reg        expiry_flag;
    reg        psa_watchdog;
    reg [15:0] retired;

    wire [7:0] copy_value;
    wire       mem_wr;
    wire [7:0] mem_wdata;

    op_decoder u_dec (
        .word                 (instr_word),
        .clear_accumulator_op (dec_clear),
        .watchdog_kick_op     (dec_kick),
        .register_copy_op     (dec_copy),
        .accumulator_store_op (dec_store),
        .literal_load_op      (dec_literal),
        .idle_op              ()
    );

    // The array reads one clock ahead, so a write in the executing slot
    // to the index being read now is forwarded instead of lost.
    assign copy_value = fwd_hit ? fwd_data : mem_rdata;
    assign mem_wr     = ex_valid & (ex_store | (ex_copy & ex_dest));
    assign mem_wdata  = ex_store ? accumulator : copy_value;

    file_regs u_regs (
        .clock   (clock),
        .wr_en   (mem_wr),
        .wr_addr (ex_index),
        .wr_data (mem_wdata),
        .rd_addr (instr_word[`INDEX_HI:0]),
        .rd_data (mem_rdata)
    );

    // One word enters per clock and leaves the next; nothing stalls.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ex_valid   <= 1'b0;
            ex_clear   <= 1'b0;
            ex_kick    <= 1'b0;
            ex_copy    <= 1'b0;
            ex_store   <= 1'b0;
            ex_literal <= 1'b0;
            ex_dest    <= 1'b0;
            ex_index   <= 5'h00;
            ex_imm     <= `BYTE_ZERO;
            fwd_hit    <= 1'b0;
            fwd_data   <= `BYTE_ZERO;
        end else begin
            ex_valid   <= instr_valid;
            ex_clear   <= instr_valid & dec_clear;
            ex_kick    <= instr_valid & dec_kick;
            ex_copy    <= instr_valid & dec_copy;
            ex_store   <= instr_valid & dec_store;
            ex_literal <= instr_valid & dec_literal;
            ex_dest    <= instr_word[`DEST_BIT];
            ex_index   <= instr_word[`INDEX_HI:0];
            ex_imm     <= instr_word[`IMM_HI:0];
            fwd_hit    <= mem_wr & (ex_index == instr_word[`INDEX_HI:0]);
            fwd_data   <= mem_wdata;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    reg        aw_held;
    reg        w_held;
    reg  [7:0] aw_addr;
    reg [31:0] w_data;
    reg  [3:0] w_strb;
    wire       wr_fire;
    wire       wr_low;
    wire       sw_acc;
    wire       sw_status;
    wire       sw_ctrl;
    wire       wr_mapped;
    reg        rd_mapped;
    reg [31:0] rd_value;

    assign wr_fire   = aw_held & w_held & ~s_axi_bvalid;
    assign wr_low    = wr_fire & w_strb[0];
    assign sw_acc    = wr_low & (aw_addr == `REG_ACCUM);
    assign sw_status = wr_low & (aw_addr == `REG_STATUS);
    assign sw_ctrl   = wr_low & (aw_addr == `REG_CONTROL);
    assign wr_mapped = (aw_addr == `REG_ACCUM) | (aw_addr == `REG_STATUS) |
                       (aw_addr == `REG_CONTROL) | (aw_addr == `REG_RETIRED);

    always @* begin
        rd_mapped = 1'b1;
        rd_value  = 32'h0000_0000;
        case (s_axi_araddr)
            `REG_ACCUM:   rd_value[7:0]  = accumulator;
            `REG_STATUS: begin
                rd_value[`ST_ZERO]   = zero_flag;
                rd_value[`ST_SLEEP]  = sleep_flag;
                rd_value[`ST_EXPIRY] = expiry_flag;
            end
            `REG_CONTROL: rd_value[`CTRL_PSA_BIT] = psa_watchdog;
            `REG_RETIRED: rd_value[15:0] = retired;
            default:      rd_mapped = 1'b0;
        endcase
    end

    // Each ready stays low after its handshake until its write has fired and the response is taken, so a held beat
    // is never overwritten before the write that uses it has fired.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= `BYTE_ZERO;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_value;
                s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Architectural state
    // ------------------------------------------------------------------
    // Software writes come first so that an executing instruction, which
    // is a hardware event, wins any collision in the same clock.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            accumulator     <= `ACC_RESET;
            zero_flag       <= `ZERO_RESET;
            sleep_flag      <= `SLEEP_RESET;
            expiry_flag     <= `EXPIRY_RESET;
            psa_watchdog    <= `CTRL_RESET;
        end else begin
            if (sw_acc) begin
                accumulator <= w_data[7:0];
            end
            if (sw_status) begin
                zero_flag   <= w_data[`ST_ZERO];
                sleep_flag  <= w_data[`ST_SLEEP];
                expiry_flag <= w_data[`ST_EXPIRY];
            end
            if (sw_ctrl) begin
                psa_watchdog <= w_data[`CTRL_PSA_BIT];
            end
            if (ex_clear) begin
                accumulator <= `ACC_RESET;
                zero_flag   <= 1'b1;
            end
            if (ex_kick) begin
                sleep_flag  <= 1'b1;
                expiry_flag <= 1'b1;
            end
            if (ex_copy) begin
                if (!ex_dest) begin
                    accumulator <= copy_value;
                end
                zero_flag <= (copy_value == `BYTE_ZERO);
            end
            if (ex_literal) begin
                accumulator <= ex_imm;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output pulses and retired count
    // ------------------------------------------------------------------
    // Pulses leave a register one clock after execute, so the watchdog sees a clean strobe of one cycle per executed kick
    // and the program counter one cycle per executed word.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_clear  <= 1'b0;
            prescaler_clear <= 1'b0;
            pc_advance      <= 1'b0;
        end else begin
            watchdog_clear  <= ex_kick;
            prescaler_clear <= ex_kick & psa_watchdog;
            pc_advance      <= ex_valid;
        end
    end

    // The count wraps silently at 16 bits; software takes differences.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retired <= 16'h0000;
        end else if (ex_valid) begin
            retired <= retired + 16'h0001;
        end
    end

endmodule // move_clear_unit

// ==== sim/move_clear_unit_asserts.sv ====
/*
 * Checker for the move and clear unit, bound to its top ports.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ps
`include "core_defs.vh"

module move_clear_unit_asserts (
    // Clock and reset
    input logic        clock,
    input logic        rst_n,
    // Fetch
    input logic [11:0] instr_word,
    input logic        instr_valid,
    // Core outputs
    input logic [7:0]  accumulator,
    input logic        watchdog_clear,
    input logic        prescaler_clear,
    input logic        pc_advance
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    wire kick = instr_valid && instr_word == `OP_KICK;
    wire lit  = instr_valid && instr_word[11:8] == `LITERAL_PREFIX;

    clear_acc_a: assert property (
        instr_valid && instr_word == `OP_CLEAR_ACC
        |-> ##2 accumulator == 8'h00)
        else $error("accumulator not cleared");
    kick_pulse_a: assert property (kick |-> ##2 watchdog_clear)
        else $error("watchdog clear missing");
    kick_only_a: assert property (!kick |-> ##2 !watchdog_clear)
        else $error("stray watchdog clear");
    presc_gate_a: assert property (prescaler_clear |-> watchdog_clear)
        else $error("prescaler clear without kick");
    copy_back_a: assert property (
        instr_valid && instr_word[11:6] == `COPY_PREFIX && instr_word[5]
        |-> ##2 $stable(accumulator))
        else $error("write-back touched accumulator");
    store_keep_a: assert property (
        instr_valid && instr_word[11:5] == `STORE_PREFIX
        |-> ##2 $stable(accumulator))
        else $error("store changed accumulator");
    literal_load_a: assert property (
        lit |-> ##2 {4'h0, accumulator} == ($past(instr_word, 2) & 12'h0FF))
        else $error("literal not loaded");
    idle_keep_a: assert property (
        instr_valid && instr_word == `OP_IDLE |-> ##2 $stable(accumulator))
        else $error("idle changed accumulator");
    one_cycle_a: assert property (instr_valid |-> ##2 pc_advance)
        else $error("pc advance missing");
    no_advance_a: assert property (!instr_valid |-> ##2 !pc_advance)
        else $error("stray pc advance");
endmodule // move_clear_unit_asserts

bind move_clear_unit move_clear_unit_asserts u_move_clear_unit_asserts (
    .clock, .rst_n, .instr_word, .instr_valid, .accumulator,
    .watchdog_clear, .prescaler_clear, .pc_advance);

// ==== sim/move_clear_unit_tb.sv ====
/*
 * Self-checking bench for the move and clear unit.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ps

module move_clear_unit_tb;
    logic        clock = 0, rst_n = 0, instr_valid = 0;
    logic [11:0] instr_word = 12'h000;
    logic [7:0]  accumulator, s_axi_awaddr = 0, s_axi_araddr = 0, k, f, g;
    logic        watchdog_clear, prescaler_clear, pc_advance, pw, pp, pa;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] q[$];
    int          fail_count = 0, compares = 0, cnt = 0;

    move_clear_unit u_move_clear_unit (.clock, .rst_n, .instr_word,
        .instr_valid, .accumulator, .watchdog_clear, .prescaler_clear,
        .pc_advance, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial forever #12.5 clock = ~clock;

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string nm, input logic [33:0] got, input logic [33:0] e);
        compares++;
        if (got !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, got);
        end
    endtask

    task limit(input int n);
        if (n > 50) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // Each answer is matched to the oldest noted expectation.
    always @(posedge clock) begin
        if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
            if (q.size() == 0)
                chk("unexpected answer", 34'h1, 34'h0);
            else
                chk("bus answer", s_axi_bvalid ? {s_axi_bresp, 32'h0}
                    : {s_axi_rresp, s_axi_rdata}, q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // Bus and fetch drivers
    // ------------------------------------------------------------------
    task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
        int n;
        @(posedge clock);
        n = 0;
        q.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            limit(++n);
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 0;
    endtask

    task rd(input [7:0] a, input [33:0] e);
        int n;
        @(posedge clock);
        n = 0;
        q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 0;
            limit(++n);
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 0;
    endtask

    // Words go back to back; settle ends the burst and samples pulses.
    task ex(input [11:0] w);
        instr_word <= w;
        instr_valid <= 1;
        cnt++;
        @(posedge clock);
    endtask

    task settle;
        instr_valid <= 0;
        instr_word <= 12'($urandom);
        @(posedge clock);
        #1;
        pw = watchdog_clear;
        pp = prescaler_clear;
        pa = pc_advance;
        repeat (2) @(posedge clock);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clock);
        limit(99);
    end

    initial begin
        void'($urandom(32'h12DBCC36));
        k = 8'($urandom_range(255, 1));
        f = 8'($urandom_range(31, 0));
        g = f ^ 8'h01;
        repeat (12) @(posedge clock);
        rst_n <= 1;
        rd(8'h04, 34'h18);
        wr(8'h00, 32'hA5, 4'hF, 2'h0);
        wr(8'h00, 32'h3C, 4'h0, 2'h0);
        rd(8'h00, 34'hA5);
        rd(8'h10, 34'h200000000);
        wr(8'h10, 32'h1, 4'hF, 2'h2);
        wr(8'h04, 32'h04, 4'hF, 2'h0);
        ex({4'hC, k});
        ex({7'h01, f[4:0]});
        ex({4'hC, ~k});
        settle();
        rd(8'h04, 34'h04);
        ex({6'h08, 1'b0, f[4:0]});
        settle();
        chk("accumulator", accumulator, k);
        rd(8'h04, 34'h00);
        ex(12'h040);
        settle();
        chk("accumulator", accumulator, 0);
        rd(8'h04, 34'h04);
        ex({6'h08, 1'b0, f[4:0]});
        ex(12'hC00);
        ex({7'h01, g[4:0]});
        ex({6'h08, 1'b1, g[4:0]});
        ex(12'hC33);
        settle();
        chk("accumulator", accumulator, 8'h33);
        rd(8'h04, 34'h04);
        ex({6'h08, 1'b0, g[4:0]});
        settle();
        chk("accumulator", accumulator, 0);
        for (int c = 0; c < 2; c++) begin
            wr(8'h08, c, 4'hF, 2'h0);
            wr(8'h04, 32'h04, 4'hF, 2'h0);
            ex(12'h004);
            settle();
            chk("watchdog_clear", pw, 1);
            chk("prescaler_clear", pp, c);
            rd(8'h04, 34'h1C);
        end
        ex(12'h000);
        settle();
        chk("idle pulses", {pa, pw}, 2'b10);
        chk("accumulator", accumulator, 0);
        rd(8'h04, 34'h1C);
        rd(8'h0C, cnt);
        report_and_stop();
    end
endmodule // move_clear_unit_tb
